// ### sbx_exec.sv
// Summary of operation
// - literal shift: DE prefix, base www, dest dddd, bits d100, count kkkk
// - register-count shift uses the whole count register, low four bits as the count when it is 15 or less
// - multi-bit shift fills vacated upper bits with base bit 15
// - register-count shift: same prefix, bits d000, count register low nibble
// - count above 15 gives 0x0 for positive base, 0xFFFF for negative
// - both shift forms are word only, no byte variant
// - register-count shift uses direct register addressing only
// - shifts set only N and Z, carry kept, one cycle
// - file bit clear: A9 prefix, word address field, index bits split
// - file bit clear addresses 0..8191 byte, even up to 8190 word
// - bit index counts from bit 0; selected bit forced to zero
// - register bit clear: A1 prefix, bbbb index, B flag, ppp mode, ssss
// - byte select bit: 0 word, 1 byte
// - register bit clear: direct or indirect with pre/post inc/dec
// - unconditional branch: 37 prefix, 16-bit signed offset, two cycles
// - taken branch target is PC plus 2 plus twice the offset
// - offset is two's complement program words from next instruction
// - relative branch reaches 32K instructions either way
// - unsigned greater-or-equal branch shares the branch-on-carry decode
// - taken branch executes a no-operation in its second cycle
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module sbx_exec
	import sbx_pkg::*;
#(
	parameter int DMEM_WORDS = 4096
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic exec_busy
);
	sbx_regs_t s_q;
	sbx_regs_t s_d;
	logic [15:0] dmem [DMEM_WORDS];
	logic mem_we;
	logic [11:0] mem_wa;
	logic [15:0] mem_wd;

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic map_ok(input logic [15:0] a);
		logic ok;
		ok = (a == SBX_A_INSTR) || (a == SBX_A_PC) || (a == SBX_A_STAT) ||
			(a == SBX_A_CYC) || (a[15:6] == SBX_A_WREG[15:6]) ||
			(a[15:14] == SBX_A_DMEM[15:14]);
		return ok && (a[1:0] == 2'b00);
	endfunction : map_ok

	always_comb begin
		logic [23:0] ins;
		logic [15:0] base;
		logic [15:0] cnt_src;
		logic [3:0] cnt;
		logic sat;
		logic [15:0] res;
		logic [3:0] bi;
		logic [15:0] mask;
		logic [15:0] ptr;
		logic [15:0] ea;
		logic [15:0] step;
		logic [3:0] rn;
		logic taken;
		logic [23:0] tgt;
		logic [31:0] wv;
		logic [31:0] stat;
		logic [11:0] ridx;
		logic wr_instr;
		logic wr_pc;
		logic wr_stat;
		logic wr_wreg;
		logic wr_dmem;
		logic rd_instr;
		logic rd_pc;
		logic rd_stat;
		logic rd_cyc;
		logic rd_wreg;
		logic rd_dmem;
		s_d = s_q;
		mem_we = 1'b0;
		mem_wa = '0;
		mem_wd = '0;
		ins = s_q.instr;
		base = s_q.wreg[ins[14:11]];
		cnt_src = '0;
		cnt = '0;
		sat = 1'b0;
		res = '0;
		bi = '0;
		mask = '0;
		ptr = '0;
		ea = '0;
		step = '0;
		rn = ins[3:0];
		taken = 1'b0;
		tgt = s_q.pc + 24'h000002;
		wv = '0;
		stat = '0;
		ridx = '0;
		// write decode on the held address; unaligned words match nothing
		wr_instr = (s_q.awaddr == SBX_A_INSTR);
		wr_pc = (s_q.awaddr == SBX_A_PC);
		wr_stat = (s_q.awaddr == SBX_A_STAT);
		wr_wreg = (s_q.awaddr[15:6] == SBX_A_WREG[15:6]) &&
			(s_q.awaddr[1:0] == 2'b00);
		wr_dmem = (s_q.awaddr[15:14] == SBX_A_DMEM[15:14]) &&
			(s_q.awaddr[1:0] == 2'b00);
		// read decode on the live address, latched in the take cycle and presented the cycle after
		rd_instr = (s_axi_araddr == SBX_A_INSTR);
		rd_pc = (s_axi_araddr == SBX_A_PC);
		rd_stat = (s_axi_araddr == SBX_A_STAT);
		rd_cyc = (s_axi_araddr == SBX_A_CYC);
		rd_wreg = (s_axi_araddr[15:6] == SBX_A_WREG[15:6]) &&
			(s_axi_araddr[1:0] == 2'b00);
		rd_dmem = (s_axi_araddr[15:14] == SBX_A_DMEM[15:14]) &&
			(s_axi_araddr[1:0] == 2'b00);

		// instruction execution
		case (s_q.st)
			SBX_EXEC: begin
				case (ins[23:16])
					SBX_OP_SHIFT: begin
						if (ins[15] && ins[5:4] == 2'b00) begin
							if (ins[6]) begin
								cnt_src = {12'h000, ins[3:0]};
							end else begin
								cnt_src = s_q.wreg[ins[3:0]];
							end
							cnt = cnt_src[3:0];
							// only the register form can carry a count above 15
							sat = |cnt_src[15:4];
							res = 16'($signed(base) >>> cnt);
							if (sat) begin
								res = base[15] ? 16'hFFFF : 16'h0000;
							end
							s_d.wreg[ins[10:7]] = res;
							// N and Z only, carry kept
							s_d.flag_n = res[15];
							s_d.flag_z = (res == 16'h0000);
						end else begin
							s_d.illegal = 1'b1;
						end
					end
					SBX_OP_BITCLR_F: begin
						bi = {ins[15:13], ins[0]};
						// even word address, byte forms folded in
						mem_wa = ins[12:1];
						mem_wd = dmem[ins[12:1]] & ~(16'h0001 << bi);
						mem_we = 1'b1;
					end
					SBX_OP_BITCLR_W: begin
						if (!ins[11] && ins[9:7] == 3'b000 && ins[6:4] <= 3'h5) begin
							bi = ins[15:12];
							ptr = s_q.wreg[rn];
							step = ins[10] ? 16'h0001 : 16'h0002;
							mask = 16'h0001 << (ins[10] ? {1'b0, bi[2:0]} : bi);
							case (ins[6:4])
								SBX_AM_PREINC: ea = ptr + step;
								SBX_AM_PREDEC: ea = ptr - step;
								default: ea = ptr;
							endcase
							case (ins[6:4])
								SBX_AM_POSTINC: s_d.wreg[rn] = ptr + step;
								SBX_AM_POSTDEC: s_d.wreg[rn] = ptr - step;
								SBX_AM_PREINC, SBX_AM_PREDEC: s_d.wreg[rn] = ea;
								default: ;
							endcase
							if (ins[6:4] == SBX_AM_DIR) begin
								s_d.wreg[rn] = ptr & ~mask;
							end else begin
								// byte access to an odd address works on the high byte
								if (ins[10] && ea[0]) begin
									mask = {mask[7:0], 8'h00};
								end
								mem_wa = ea[12:1];
								mem_wd = dmem[ea[12:1]] & ~mask;
								mem_we = 1'b1;
							end
						end else begin
							s_d.illegal = 1'b1;
						end
					end
					SBX_OP_BRA: begin
						taken = 1'b1;
					end
					SBX_OP_BRA_C: begin
						taken = s_q.flag_c;
					end
					SBX_OP_BRA_W: begin
						if (ins[15:4] == SBX_BRA_W_MID) begin
							taken = 1'b1;
							tgt = s_q.pc + 24'h000002 +
								{{7{s_q.wreg[rn][15]}}, s_q.wreg[rn], 1'b0};
						end else begin
							s_d.illegal = 1'b1;
						end
					end
					// unknown opcode: flag it and step over the word
					default: s_d.illegal = 1'b1;
				endcase
				if (taken && ins[23:16] != SBX_OP_BRA_W) begin
					tgt = s_q.pc + 24'h000002 + {{7{ins[15]}}, ins[15:0], 1'b0};
				end
				s_d.pc = tgt;
				s_d.st = taken ? SBX_NOP : SBX_IDLE;
				s_d.ncyc = taken ? SBX_CYC_TWO : SBX_CYC_ONE;
			end
			// the already fetched follow-on slot is spent doing nothing
			SBX_NOP: s_d.st = SBX_IDLE;
			default: s_d.st = SBX_IDLE;
		endcase

		// write channel
		if (s_axi_awvalid && s_q.awready) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wready) begin
			s_d.w_got = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		// writes complete only while idle, so no clash with execution
		if (s_q.aw_got && s_q.w_got && !s_q.bvalid && s_q.st == SBX_IDLE) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = map_ok(s_q.awaddr) ? SBX_RESP_OKAY : SBX_RESP_SLVERR;
			if (wr_instr) begin
				wv = merge({8'h00, s_q.instr}, s_q.wdata, s_q.wstrb);
				s_d.instr = wv[23:0];
				s_d.st = SBX_EXEC;
			end else if (wr_pc) begin
				wv = merge({8'h00, s_q.pc}, s_q.wdata, s_q.wstrb);
				s_d.pc = {wv[23:1], 1'b0};
			end else if (wr_stat && s_q.wstrb[0]) begin
				s_d.flag_c = s_q.wdata[SBX_ST_C];
				s_d.flag_z = s_q.wdata[SBX_ST_Z];
				s_d.flag_n = s_q.wdata[SBX_ST_N];
			end else if (wr_wreg) begin
				wv = merge({16'h0000, s_q.wreg[s_q.awaddr[5:2]]}, s_q.wdata,
					s_q.wstrb);
				s_d.wreg[s_q.awaddr[5:2]] = wv[15:0];
			end else if (wr_dmem) begin
				wv = merge({16'h0000, dmem[s_q.awaddr[13:2]]}, s_q.wdata,
					s_q.wstrb);
				mem_we = 1'b1;
				mem_wa = s_q.awaddr[13:2];
				mem_wd = wv[15:0];
			end
			if (wr_stat && s_q.wstrb[1] && s_q.wdata[SBX_ST_ILL]) begin
				s_d.illegal = 1'b0;
			end
		end
		// ready drops after a take and returns once the response is issued
		s_d.awready = !s_d.aw_got;
		s_d.wready = !s_d.w_got;

		// read channel
		stat = '0;
		stat[SBX_ST_C] = s_q.flag_c;
		stat[SBX_ST_Z] = s_q.flag_z;
		stat[SBX_ST_N] = s_q.flag_n;
		stat[SBX_ST_BUSY] = (s_q.st != SBX_IDLE);
		stat[SBX_ST_ILL] = s_q.illegal;
		ridx = s_axi_araddr[13:2];
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
			s_d.arready = 1'b1;
		end
		if (s_axi_arvalid && s_q.arready) begin
			s_d.arready = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rdata = '0;
			s_d.rresp = map_ok(s_axi_araddr) ? SBX_RESP_OKAY : SBX_RESP_SLVERR;
			if (rd_instr) begin
				s_d.rdata = {8'h00, s_q.instr};
			end else if (rd_pc) begin
				s_d.rdata = {8'h00, s_q.pc};
			end else if (rd_stat) begin
				s_d.rdata = stat;
			end else if (rd_cyc) begin
				s_d.rdata = {30'h0, s_q.ncyc};
			end else if (rd_wreg) begin
				s_d.rdata = {16'h0000, s_q.wreg[s_axi_araddr[5:2]]};
			end else if (rd_dmem) begin
				s_d.rdata = {16'h0000, dmem[ridx]};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{st: SBX_IDLE, awready: 1'b1, wready: 1'b1,
				arready: 1'b1, pc: SBX_PC_RST, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// data memory has no reset; software loads it over the bus
	always_ff @(posedge clk) begin
		if (mem_we) begin
			dmem[mem_wa] <= mem_wd;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			exec_busy <= 1'b0;
		end else begin
			// taken from the next state so busy lines up with the state register
			exec_busy <= (s_d.st != SBX_IDLE);
		end
	end

	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
endmodule : sbx_exec
`default_nettype wire

// ### sbx_exec_props.sv
`timescale 1ns/100ps
`default_nettype none
module sbx_exec_props
	import sbx_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic exec_busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_busy_two_max: assert property (
		exec_busy [*2] |=> !exec_busy) else $error("busy over two cycles");
	a_shift_done: assert property (
		$rose(exec_busy) |-> ##[1:2] !exec_busy) else $error("busy unbounded");
	a_busy_on_resp: assert property (
		$rose(exec_busy) |-> s_axi_bvalid) else $error("busy without write");
	a_aw_taken: assert property (
		s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready stayed high");
	a_w_taken: assert property (
		s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("wready stayed high");
	a_ar_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_r_release: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read not released");
	a_b_release: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response stuck");
	a_err_zero: assert property (
		s_axi_rvalid && s_axi_rresp == SBX_RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read carries data");
	c_two_cycle: cover property (exec_busy [*2]);
	c_one_cycle: cover property ($rose(exec_busy) ##1 !exec_busy);
	c_err_read: cover property (s_axi_rvalid && s_axi_rresp == SBX_RESP_SLVERR);
endmodule : sbx_exec_props
bind sbx_exec sbx_exec_props i_props (.clk, .rst_n, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .exec_busy);
`default_nettype wire

// ### sbx_exec_test.sv
`timescale 1ns/100ps
`default_nettype none
module sbx_exec_test
	import sbx_pkg::*;
;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, exec_busy;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rv;
	int n_mismatch = 0, checks = 0, cyc_n = 0, nb = 0;

	sbx_exec #(.DMEM_WORDS(4096)) i_dut (.clk, .rst_n, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .exec_busy);

	always #10 clk = ~clk;

	task automatic test_done;
		if (n_mismatch == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done

	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n > 5000) begin
			n_mismatch++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		rsp = s_axi_bresp;
	endtask : wr

	task automatic rd(input logic [15:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		rv = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask : rd

	task automatic rchk(input logic [15:0] a, input logic [31:0] e);
		rd(a);
		chk(rv, e);
	endtask : rchk

	task automatic ex(input logic [23:0] ins);
		wr(SBX_A_INSTR, {8'h0, ins});
		nb = 0;
		while (exec_busy !== 1'h0) begin
			nb++;
			@(posedge clk);
		end
	endtask : ex

	task automatic t_shift;
		logic [15:0] bv[4] = '{16'h80FF, 16'h70FF, 16'h6688, 16'h8765};
		logic [15:0] cv[4] = '{16'h0006, 16'h000F, 16'h000A, 16'h88E4};
		logic [15:0] ev[4] = '{16'hFE03, 16'h0000, 16'h0019, 16'hFFFF};
		logic [15:0] r;
		for (int i = 0; i < 4; i++) begin
			wr(SBX_A_WREG, {16'h0, bv[i]});
			wr(SBX_A_WREG + 16'h14, {16'h0, cv[i]});
			wr(SBX_A_STAT, 32'h1);
			ex({SBX_OP_SHIFT, 5'h10, 4'h1, i < 2 ? {3'h4, cv[i][3:0]} : 7'h05});
			chk(nb, 32'h1);
			r = ev[i];
			rchk(SBX_A_WREG + 16'h4, {16'h0, r});
			rchk(SBX_A_STAT, {28'h0, r[15], 1'h0, r == 16'h0, 1'h1});
			rchk(SBX_A_CYC, 32'h1);
		end
	endtask : t_shift

	task automatic t_bit_clear;
		logic [7:0] ea[6] = '{8'h20, 8'h20, 8'h20, 8'h20, 8'h22, 8'h1E};
		logic [7:0] wa[6] = '{8'h20, 8'h20, 8'h22, 8'h1E, 8'h22, 8'h1E};
		wr(SBX_A_WREG + 16'h8, 32'hF234);
		ex({SBX_OP_BITCLR_W, 4'hF, 4'h0, 1'h0, SBX_AM_DIR, 4'h2});
		rchk(SBX_A_WREG + 16'h8, 32'h7234);
		ex({SBX_OP_BITCLR_W, 4'h2, 4'h4, 1'h0, SBX_AM_DIR, 4'h2});
		rchk(SBX_A_WREG + 16'h8, 32'h7230);
		for (int m = 1; m < 6; m++) begin
			wr(SBX_A_WREG + 16'hC, 32'h20);
			for (int k = 0; k < 3; k++) wr(16'h403C + 16'(4 * k), 32'hFFFF);
			ex({SBX_OP_BITCLR_W, 4'h0, 4'h0, 1'h0, 3'(m), 4'h3});
			rchk(16'h4000 + 16'(2 * ea[m]), 32'hFFFE);
			rchk(SBX_A_WREG + 16'hC, {24'h0, wa[m]});
		end
	endtask : t_bit_clear

	task automatic t_file;
		wr(16'h4800, 32'hFFFF);
		ex({SBX_OP_BITCLR_F, 3'h4, 12'h200, 1'h1});
		rchk(16'h4800, 32'hFDFF);
		wr(16'h7FFC, 32'hFFFF);
		ex({SBX_OP_BITCLR_F, 3'h0, 12'hFFF, 1'h0});
		rchk(16'h7FFC, 32'hFFFE);
	endtask : t_file

	task automatic t_branch;
		logic [23:0] pc[6] = '{24'h2000, 24'h2000, 24'h2000, 24'h2000,
			24'h2000, 24'h10000};
		logic [23:0] op[6] = '{24'h370004, 24'h37F9B2, 24'h310003,
			24'h310003, 24'h016007, 24'h378000};
		logic [23:0] tg[6] = '{24'h200A, 24'h1366, 24'h2008, 24'h2002,
			24'h210A, 24'h0002};
		wr(SBX_A_WREG + 16'h1C, 32'h84);
		for (int i = 0; i < 6; i++) begin
			wr(SBX_A_STAT, {31'h0, i != 3});
			wr(SBX_A_PC, {8'h0, pc[i]});
			ex(op[i]);
			chk(nb, i == 3 ? 32'h1 : 32'h2);
			rchk(SBX_A_PC, {8'h0, tg[i]});
			rchk(SBX_A_CYC, i == 3 ? 32'h1 : 32'h2);
			rchk(SBX_A_STAT, {31'h0, i != 3});
		end
	endtask : t_branch

	task automatic t_unmapped;
		rd(16'h0010);
		chk({30'h0, rsp}, {30'h0, SBX_RESP_SLVERR});
		chk(rv, 32'h0);
		wr(16'h0014, 32'h1);
		chk({30'h0, rsp}, {30'h0, SBX_RESP_SLVERR});
	endtask : t_unmapped

	task automatic t_illegal;
		wr(SBX_A_STAT, 32'h1);
		wr(SBX_A_PC, 32'h100);
		ex(24'hFF0000);
		chk(nb, 32'h1);
		rchk(SBX_A_STAT, 32'h201);
		rchk(SBX_A_PC, 32'h102);
		wr(SBX_A_STAT, 32'h200);
		rchk(SBX_A_STAT, 32'h0);
	endtask : t_illegal

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		rchk(SBX_A_PC, 32'h0);
		rchk(SBX_A_STAT, 32'h0);
		t_shift();
		t_bit_clear();
		t_file();
		t_branch();
		t_unmapped();
		t_illegal();
		test_done();
	end
endmodule : sbx_exec_test
`default_nettype wire

// ### sbx_pkg.sv
package sbx_pkg;
	// register byte offsets on the AXI4-Lite slave
	localparam logic [15:0] SBX_A_INSTR = 16'h0000;
	localparam logic [15:0] SBX_A_PC = 16'h0004;
	localparam logic [15:0] SBX_A_STAT = 16'h0008;
	localparam logic [15:0] SBX_A_CYC = 16'h000C;
	localparam logic [15:0] SBX_A_WREG = 16'h0040;
	localparam logic [15:0] SBX_A_DMEM = 16'h4000;
	// status word bit positions
	localparam int SBX_ST_C = 0;
	localparam int SBX_ST_Z = 1;
	localparam int SBX_ST_N = 3;
	localparam int SBX_ST_BUSY = 8;
	localparam int SBX_ST_ILL = 9;
	// opcode bytes, bits 23:16 of the instruction; SBX_BRA_W_MID holds bits 15:4 of the register branch
	localparam logic [7:0] SBX_OP_SHIFT = 8'hDE;
	localparam logic [7:0] SBX_OP_BITCLR_F = 8'hA9;
	localparam logic [7:0] SBX_OP_BITCLR_W = 8'hA1;
	localparam logic [7:0] SBX_OP_BRA = 8'h37;
	localparam logic [7:0] SBX_OP_BRA_C = 8'h31;
	localparam logic [7:0] SBX_OP_BRA_W = 8'h01;
	localparam logic [11:0] SBX_BRA_W_MID = 12'h600;
	// source addressing modes of the register bit clear
	localparam logic [2:0] SBX_AM_DIR = 3'h0;
	localparam logic [2:0] SBX_AM_IND = 3'h1;
	localparam logic [2:0] SBX_AM_POSTINC = 3'h2;
	localparam logic [2:0] SBX_AM_POSTDEC = 3'h3;
	localparam logic [2:0] SBX_AM_PREINC = 3'h4;
	localparam logic [2:0] SBX_AM_PREDEC = 3'h5;
	// reset values, cycle figures and response codes
	localparam logic [23:0] SBX_PC_RST = 24'h000000;
	localparam logic [1:0] SBX_CYC_ONE = 2'h1;
	localparam logic [1:0] SBX_CYC_TWO = 2'h2;
	localparam logic [1:0] SBX_RESP_OKAY = 2'h0;
	localparam logic [1:0] SBX_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SBX_IDLE = 3'b001,
		SBX_EXEC = 3'b010,
		SBX_NOP = 3'b100
	} sbx_state_t;

	typedef struct packed {
		sbx_state_t st;
		logic awready;
		logic wready;
		logic arready;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_got;
		logic w_got;
		logic [15:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [23:0] instr;
		logic [23:0] pc;
		logic flag_c;
		logic flag_z;
		logic flag_n;
		logic illegal;
		logic [1:0] ncyc;
		logic [15:0][15:0] wreg;
	} sbx_regs_t;
endpackage : sbx_pkg
